// file: logic/health_log_recorder.v
// Purpose: builds the error, self-test and selective self-test log sectors
//          and answers health-monitoring command checks
// Assumes: all inputs synchronous to core_clk; pulses last one cycle
// Notes:   a log event arriving while its kind is pending or busy is dropped
//
// Overview of operation
// - error entry: five 12-byte snapshots then a 30-byte error record
// - snapshot bytes 0-6 shadow registers, byte 7 the command
// - snapshot bytes 8-11 millisecond count at acceptance, free wrap
// - record byte 0 reserved, 1-7 completion registers
// - record bytes 8-26 extended information of our own
// - record byte 27 low nibble holds device state at issue
// - state byte upper nibble is implementation defined
// - record bytes 28-29 lifetime stamp, low byte first
// - self-test log: revision, then 24-byte descriptors from byte 2
// - at most 21 descriptors, newest replaces oldest circularly
// - byte 508 points at newest descriptor, 0 when empty
// - selective log spans at bytes 2-81 readable and host writable
// - selective log shows current LBA and span, read only
// - selective feature flags and pending time are host writable
// - missing key gives status 51h error 04h
// - invalid subcommand gives status 51h error 04h
// - disabled state rejects all but enable with 51h and 04h
// - attribute table read failure gives 51h with 10h
// - attribute table write failure gives 51h with 40h
// - last sector byte makes the 8-bit sum of 512 bytes zero
// - error log pointer names newest entry, values 1 to 5
// - error count totals errors and saturates
// - multibyte fields stored least significant byte first
`timescale 1ns/1ps
`include "hlr_consts.vh"

module health_log_recorder #(
	parameter CYCLES_PER_MS = `MS_PERIOD_NS / `CLK_PERIOD_NS
) (
	// clock and reset
	input  wire        core_clk,
	input  wire        reset,
	// command block at command write
	input  wire        cmd_write,
	input  wire [7:0]  cmd_byte,
	input  wire [7:0]  dev_ctl,
	input  wire [7:0]  features,
	input  wire [7:0]  sect_cnt,
	input  wire [7:0]  lba_low,
	input  wire [7:0]  lba_mid,
	input  wire [7:0]  lba_high,
	input  wire [7:0]  dev_head,
	input  wire [3:0]  dev_state,
	// completion of a failed command
	input  wire        cmd_fail,
	input  wire [7:0]  done_error,
	input  wire [7:0]  done_sect_cnt,
	input  wire [7:0]  done_lba_low,
	input  wire [7:0]  done_lba_mid,
	input  wire [7:0]  done_lba_high,
	input  wire [7:0]  done_dev_head,
	input  wire [7:0]  done_status,
	input  wire [15:0] life_stamp,
	// self-test result and progress
	input  wire        st_done,
	input  wire [7:0]  st_number,
	input  wire [7:0]  st_status,
	input  wire [7:0]  st_checkpoint,
	input  wire [31:0] st_fail_lba,
	input  wire        prog_update,
	input  wire [63:0] prog_lba,
	input  wire [15:0] prog_span,
	// attribute table health
	input  wire        attr_rd_fail,
	input  wire        attr_wr_fail,
	// host sector access
	input  wire        rd_en,
	input  wire [1:0]  rd_sel,
	input  wire [8:0]  rd_addr,
	input  wire        sel_wr_en,
	input  wire [8:0]  sel_wr_addr,
	input  wire [7:0]  sel_wr_data,
	output reg         rd_valid,
	output reg  [7:0]  rd_data,
	output reg         sel_busy,
	// health command answer
	output reg         hm_resp_valid,
	output reg  [7:0]  hm_resp_status,
	output reg  [7:0]  hm_resp_error,
	output reg         hm_enabled
);

	// one-hot writer states
	localparam [3:0] S_IDLE = 4'b0001;
	localparam [3:0] S_ERR  = 4'b0010;
	localparam [3:0] S_ST   = 4'b0100;
	localparam [3:0] S_PROG = 4'b1000;

	reg  [3:0]   state_reg;
	reg  [3:0]   state_next;
	reg  [6:0]   idx_reg;
	reg  [95:0]  snap_reg [0:4];
	reg  [3:0]   issue_state_reg;
	reg  [719:0] entry_reg;
	reg  [191:0] desc_reg;
	reg  [79:0]  prog_reg;
	reg          err_pend_reg, st_pend_reg, prog_pend_reg;
	reg  [2:0]   eptr_reg;
	reg  [4:0]   sptr_reg;
	reg  [15:0]  err_count_reg;
	reg          init_reg;
	reg          e_we, s_we, p_we;
	reg  [8:0]   e_wa, s_wa, p_wa;
	reg  [7:0]   e_wd, s_wd, p_wd;
	wire [31:0]  ms_now;
	wire [7:0]   e_rd, s_rd, p_rd;
	wire [2:0]   eslot;
	wire [4:0]   sslot;
	wire [8:0]   e_base;
	wire [8:0]   s_base;
	wire         host_wr_ok;

	// host-writable bytes of the selective log
	function sel_writable;
		input [8:0] a;
		begin
			sel_writable = (a <= `SEL_SPAN_LAST_OFS) ||
				(a == `SEL_FLAG_LO_OFS) || (a == `SEL_FLAG_HI_OFS) ||
				(a == `SEL_PEND_LO_OFS) || (a == `SEL_PEND_HI_OFS);
		end
	endfunction

	// -------------------------------------------------------------------
	// submodules
	// -------------------------------------------------------------------
	ms_timer #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_ms (
		.core_clk (core_clk),
		.reset    (reset),
		.ms_count (ms_now)
	);

	log_sector u_err (
		.core_clk (core_clk),
		.reset    (reset),
		.wr_en    (e_we),
		.wr_addr  (e_wa),
		.wr_data  (e_wd),
		.rd_addr  (rd_addr),
		.rd_byte  (e_rd)
	);

	log_sector u_st (
		.core_clk (core_clk),
		.reset    (reset),
		.wr_en    (s_we),
		.wr_addr  (s_wa),
		.wr_data  (s_wd),
		.rd_addr  (rd_addr),
		.rd_byte  (s_rd)
	);

	log_sector u_sel (
		.core_clk (core_clk),
		.reset    (reset),
		.wr_en    (p_we),
		.wr_addr  (p_wa),
		.wr_data  (p_wd),
		.rd_addr  (rd_addr),
		.rd_byte  (p_rd)
	);

	// -------------------------------------------------------------------
	// command snapshot history
	// -------------------------------------------------------------------
	// shift register, slot 0 oldest
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_hist
			always @(posedge core_clk or posedge reset) begin
				if (reset) begin
					snap_reg[g] <= 96'h0;
				end else if (cmd_write) begin
					snap_reg[g] <= snap_reg[g + 1];
				end
			end
		end
	endgenerate

	// newest snapshot, timestamp low byte first
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			snap_reg[4]     <= 96'h0;
			issue_state_reg <= 4'h0;
		end else if (cmd_write) begin
			snap_reg[4]     <= {ms_now, cmd_byte, dev_head, lba_high,
				lba_mid, lba_low, sect_cnt, features, dev_ctl};
			issue_state_reg <= dev_state;
		end
	end

	// -------------------------------------------------------------------
	// event capture
	// -------------------------------------------------------------------
	// next slots; pointers never leave their documented ranges
	assign eslot  = (eptr_reg == `ELOG_SLOTS) ? 3'h0 : eptr_reg;
	assign sslot  = (sptr_reg == `STLOG_SLOTS) ? 5'h00 : sptr_reg;
	assign e_base = `ELOG_FIRST_OFS +
		`ELOG_ENTRY_LEN * {6'h00, eptr_reg - 3'h1};
	assign s_base = `STLOG_FIRST_OFS +
		`STLOG_DESC_LEN * {4'h0, sptr_reg - 5'h01};
	assign host_wr_ok = sel_wr_en && (state_reg != S_PROG) &&
		sel_writable(sel_wr_addr);

	// latch each event only when its kind is free, so no entry tears
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			entry_reg     <= 720'h0;
			desc_reg      <= 192'h0;
			prog_reg      <= 80'h0;
			err_pend_reg  <= 1'b0;
			st_pend_reg   <= 1'b0;
			prog_pend_reg <= 1'b0;
			err_count_reg <= 16'h0000;
		end else begin
			if (cmd_fail && (err_count_reg != 16'hFFFF)) begin
				err_count_reg <= err_count_reg + 16'h0001;
			end
			if (cmd_fail && !err_pend_reg && (state_reg != S_ERR)) begin
				err_pend_reg <= 1'b1;
				entry_reg <= {life_stamp, `STATE_HI_NIBBLE,
					issue_state_reg, 120'h0, ms_now, done_status,
					done_dev_head, done_lba_high, done_lba_mid,
					done_lba_low, done_sect_cnt, done_error, 8'h00,
					snap_reg[4], snap_reg[3], snap_reg[2],
					snap_reg[1], snap_reg[0]};
			end else if (state_next == S_ERR && state_reg == S_IDLE) begin
				err_pend_reg <= 1'b0;
			end
			if (st_done && !st_pend_reg && (state_reg != S_ST)) begin
				st_pend_reg <= 1'b1;
				desc_reg <= {120'h0, st_fail_lba, st_checkpoint,
					life_stamp, st_status, st_number};
			end else if (state_next == S_ST && state_reg == S_IDLE) begin
				st_pend_reg <= 1'b0;
			end
			if (prog_update && !prog_pend_reg && (state_reg != S_PROG)) begin
				prog_pend_reg <= 1'b1;
				prog_reg      <= {prog_span, prog_lba};
			end else if (state_next == S_PROG && state_reg == S_IDLE) begin
				prog_pend_reg <= 1'b0;
			end
		end
	end

	// -------------------------------------------------------------------
	// sector writer
	// -------------------------------------------------------------------
	// one byte per cycle; errors first, host writes hold off progress but are refused while it runs
	always @* begin
		state_next = state_reg;
		case (state_reg)
			S_IDLE: begin
				if (init_reg) begin
					state_next = S_IDLE;
				end else if (err_pend_reg) begin
					state_next = S_ERR;
				end else if (st_pend_reg) begin
					state_next = S_ST;
				end else if (prog_pend_reg && !sel_wr_en) begin
					state_next = S_PROG;
				end
			end
			S_ERR: begin
				if (idx_reg == `ELOG_ENTRY_BYTES + 7'h02) begin
					state_next = S_IDLE;
				end
			end
			S_ST: begin
				if (idx_reg == `STLOG_DESC_BYTES) begin
					state_next = S_IDLE;
				end
			end
			S_PROG: begin
				if (idx_reg == `SEL_PROG_BYTES - 7'h01) begin
					state_next = S_IDLE;
				end
			end
			default: begin
				state_next = S_IDLE;
			end
		endcase
	end

	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_reg <= S_IDLE;
			idx_reg   <= 7'h00;
			init_reg  <= 1'b1;
			eptr_reg  <= 3'h0;
			sptr_reg  <= 5'h00;
			sel_busy  <= 1'b0;
		end else begin
			state_reg <= state_next;
			init_reg  <= 1'b0;
			sel_busy  <= (state_next == S_PROG);
			idx_reg   <= (state_next == state_reg && state_reg != S_IDLE) ?
				idx_reg + 7'h01 : 7'h00;
			if (state_reg == S_IDLE && state_next == S_ERR) begin
				eptr_reg <= eslot + 3'h1;
			end
			if (state_reg == S_IDLE && state_next == S_ST) begin
				sptr_reg <= sslot + 5'h01;
			end
		end
	end

	// byte steering for the three sector write ports
	always @* begin
		e_we = 1'b0;
		e_wa = `LOG_REV_OFS;
		e_wd = `LOG_REV_VAL;
		s_we = 1'b0;
		s_wa = `LOG_REV_OFS;
		s_wd = `LOG_REV_VAL;
		p_we = 1'b0;
		p_wa = `LOG_REV_OFS;
		p_wd = `LOG_REV_VAL;
		if (init_reg) begin
			e_we = 1'b1;
			s_we = 1'b1;
		end else if (state_reg == S_ERR) begin
			e_we = 1'b1;
			if (idx_reg < `ELOG_ENTRY_BYTES) begin
				// slot base was fixed by the pointer at entry start
				e_wa = e_base + {2'b00, idx_reg};
				e_wd = entry_reg[{idx_reg, 3'b000} +: 8];
			end else if (idx_reg == `ELOG_ENTRY_BYTES) begin
				e_wa = `ELOG_PTR_OFS;
				e_wd = {5'h00, eptr_reg};
			end else if (idx_reg == `ELOG_ENTRY_BYTES + 7'h01) begin
				e_wa = `ELOG_CNT_LO_OFS;
				e_wd = err_count_reg[7:0];
			end else begin
				e_wa = `ELOG_CNT_HI_OFS;
				e_wd = err_count_reg[15:8];
			end
		end else if (state_reg == S_ST) begin
			s_we = 1'b1;
			if (idx_reg < `STLOG_DESC_BYTES) begin
				s_wa = s_base + {2'b00, idx_reg};
				s_wd = desc_reg[{idx_reg[4:0], 3'b000} +: 8];
			end else begin
				s_wa = `STLOG_PTR_OFS;
				s_wd = {3'h0, sptr_reg};
			end
		end
		// host writes run beside the other two writers
		if (init_reg) begin
			p_we = 1'b1;
		end else if (state_reg == S_PROG) begin
			p_we = 1'b1;
			p_wa = `SEL_PROG_OFS + {2'b00, idx_reg};
			p_wd = prog_reg[{idx_reg[3:0], 3'b000} +: 8];
		end else if (host_wr_ok) begin
			p_we = 1'b1;
			p_wa = sel_wr_addr;
			p_wd = sel_wr_data;
		end
	end

	// -------------------------------------------------------------------
	// host read port
	// -------------------------------------------------------------------
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rd_valid <= 1'b0;
			rd_data  <= 8'h00;
		end else begin
			rd_valid <= rd_en;
			case (rd_sel)
				`LOG_SEL_ERR:       rd_data <= e_rd;
				`LOG_SEL_SELFTEST:  rd_data <= s_rd;
				`LOG_SEL_SELECTIVE: rd_data <= p_rd;
				default:            rd_data <= 8'h00;
			endcase
		end
	end

	// -------------------------------------------------------------------
	// health-monitoring command check
	// -------------------------------------------------------------------
	// checks run in order key, subcommand, enable state, table health
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			hm_resp_valid  <= 1'b0;
			hm_resp_status <= `HM_STAT_GOOD;
			hm_resp_error  <= `HM_ERR_NONE;
			hm_enabled     <= `HM_ENABLE_RST;
		end else begin
			hm_resp_valid <= cmd_write && (cmd_byte == `HM_CMD);
			if (cmd_write && (cmd_byte == `HM_CMD)) begin
				hm_resp_status <= `HM_STAT_ABORT;
				hm_resp_error  <= `HM_ERR_ABORT;
				if (lba_mid != `HM_KEY_MID || lba_high != `HM_KEY_HIGH) begin
					hm_resp_error <= `HM_ERR_ABORT;
				end else if (features < `HM_SUB_READ_DATA ||
					features > `HM_SUB_STATUS ||
					features == 8'hD7) begin
					hm_resp_error <= `HM_ERR_ABORT;
				end else if (!hm_enabled && features != `HM_SUB_ENABLE) begin
					hm_resp_error <= `HM_ERR_ABORT;
				end else if (attr_rd_fail && (features == `HM_SUB_READ_DATA
					|| features == `HM_SUB_READ_THR)) begin
					hm_resp_error <= `HM_ERR_IDNF;
				end else if (attr_wr_fail &&
					features == `HM_SUB_SAVE_ATTR) begin
					hm_resp_error <= `HM_ERR_UNC;
				end else begin
					hm_resp_status <= `HM_STAT_GOOD;
					hm_resp_error  <= `HM_ERR_NONE;
					if (features == `HM_SUB_ENABLE) begin
						hm_enabled <= 1'b1;
					end else if (features == `HM_SUB_DISABLE) begin
						hm_enabled <= 1'b0;
					end
				end
			end
		end
	end

endmodule // health_log_recorder

// file: logic/hlr_consts.vh
// Purpose: shared offsets, codes and timing figures of the health log recorder
// Assumes: included by bare name from every design file
// Notes:   definitions only
`ifndef HLR_CONSTS_VH
`define HLR_CONSTS_VH

// -----------------------------------------------------------------------
// common sector layout
// -----------------------------------------------------------------------
`define LOG_REV_OFS        9'h000
`define LOG_REV_VAL        8'h01
`define LOG_CSUM_OFS       9'h1FF
`define LOG_SEL_ERR        2'h0
`define LOG_SEL_SELFTEST   2'h1
`define LOG_SEL_SELECTIVE  2'h2

// -----------------------------------------------------------------------
// error log sector
// -----------------------------------------------------------------------
`define ELOG_PTR_OFS       9'h001
`define ELOG_FIRST_OFS     9'h002
`define ELOG_ENTRY_LEN     9'h05A
`define ELOG_ENTRY_BYTES   7'h5A
`define ELOG_SLOTS         3'h5
`define ELOG_CNT_LO_OFS    9'h1C4
`define ELOG_CNT_HI_OFS    9'h1C5
`define STATE_HI_NIBBLE    4'h0

// -----------------------------------------------------------------------
// self-test log sector
// -----------------------------------------------------------------------
`define STLOG_FIRST_OFS    9'h002
`define STLOG_DESC_LEN     9'h018
`define STLOG_DESC_BYTES   7'h18
`define STLOG_SLOTS        5'h15
`define STLOG_PTR_OFS      9'h1FC

// -----------------------------------------------------------------------
// selective self-test log sector
// -----------------------------------------------------------------------
`define SEL_SPAN_LAST_OFS  9'h051
`define SEL_PROG_OFS       9'h1EC
`define SEL_PROG_BYTES     7'h0A
`define SEL_FLAG_LO_OFS    9'h1F6
`define SEL_FLAG_HI_OFS    9'h1F7
`define SEL_PEND_LO_OFS    9'h1FC
`define SEL_PEND_HI_OFS    9'h1FD

// -----------------------------------------------------------------------
// health-monitoring command and completion codes
// -----------------------------------------------------------------------
`define HM_CMD             8'hB0
`define HM_KEY_MID         8'h4F
`define HM_KEY_HIGH        8'hC2
`define HM_SUB_READ_DATA   8'hD0
`define HM_SUB_READ_THR    8'hD1
`define HM_SUB_AUTOSAVE    8'hD2
`define HM_SUB_SAVE_ATTR   8'hD3
`define HM_SUB_OFFLINE     8'hD4
`define HM_SUB_READ_LOG    8'hD5
`define HM_SUB_WRITE_LOG   8'hD6
`define HM_SUB_ENABLE      8'hD8
`define HM_SUB_DISABLE     8'hD9
`define HM_SUB_STATUS      8'hDA
`define HM_STAT_ABORT      8'h51
`define HM_STAT_GOOD       8'h50
`define HM_ERR_ABORT       8'h04
`define HM_ERR_IDNF        8'h10
`define HM_ERR_UNC         8'h40
`define HM_ERR_NONE        8'h00
`define HM_ENABLE_RST      1'b1

// -----------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------
`define CLK_PERIOD_NS      4
`define MS_PERIOD_NS       1000000

`endif

// file: logic/ms_timer.v
// Purpose: millisecond count since power-on for command timestamps
// Assumes: core_clk at the rate in the constants header
// Notes:   the count wraps freely at 32 bits
`timescale 1ns/1ps
`include "hlr_consts.vh"

module ms_timer #(
	parameter CYCLES_PER_MS = `MS_PERIOD_NS / `CLK_PERIOD_NS
) (
	// clock and reset
	input  wire        core_clk,
	input  wire        reset,
	// count
	output reg  [31:0] ms_count
);

	reg [31:0] presc_reg;

	// -------------------------------------------------------------------
	// prescaler and count
	// -------------------------------------------------------------------
	// prescaler steps the count once a millisecond; wrap is harmless
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			presc_reg <= 32'h00000000;
			ms_count  <= 32'h00000000;
		end else if (presc_reg == CYCLES_PER_MS - 1) begin
			presc_reg <= 32'h00000000;
			ms_count  <= ms_count + 32'h00000001;
		end else begin
			presc_reg <= presc_reg + 32'h00000001;
		end
	end

endmodule // ms_timer

// file: logic/log_sector.v
// Purpose: one 512-byte log sector with a self-maintained checksum
// Assumes: one write per cycle; read is combinational
// Notes:   writes to the checksum byte are ignored
`timescale 1ns/1ps
`include "hlr_consts.vh"

module log_sector (
	// clock and reset
	input  wire       core_clk,
	input  wire       reset,
	// write port
	input  wire       wr_en,
	input  wire [8:0] wr_addr,
	input  wire [7:0] wr_data,
	// read port
	input  wire [8:0] rd_addr,
	output wire [7:0] rd_byte
);

	reg [7:0] mem [0:511];
	reg [7:0] sum_reg;
	integer   i;

	// -------------------------------------------------------------------
	// storage and running sum
	// -------------------------------------------------------------------
	// sum tracks bytes 0..510 so the checksum never needs a sweep
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			for (i = 0; i < 512; i = i + 1) begin
				mem[i] <= 8'h00;
			end
			sum_reg <= 8'h00;
		end else if (wr_en && (wr_addr != `LOG_CSUM_OFS)) begin
			mem[wr_addr] <= wr_data;
			sum_reg      <= sum_reg - mem[wr_addr] + wr_data;
		end
	end

	assign rd_byte = (rd_addr == `LOG_CSUM_OFS) ? (8'h00 - sum_reg) :
		mem[rd_addr];

endmodule // log_sector

// file: dv/hlr_monitor.sv
// Purpose: port assertions for the health log recorder
// Assumes: command, key, enable and disable codes come from the shared constants header, the rest are written out
// Notes:   bound into every recorder instance below
`timescale 1ns/1ps
`include "hlr_consts.vh"

module hlr_monitor (
	// clock and reset
	input wire       core_clk,
	input wire       reset,
	// command block
	input wire       cmd_write,
	input wire [7:0] cmd_byte,
	input wire [7:0] features,
	input wire [7:0] lba_mid,
	input wire [7:0] lba_high,
	input wire       attr_rd_fail,
	input wire       attr_wr_fail,
	// answers
	input wire       rd_en,
	input wire       rd_valid,
	input wire       sel_busy,
	input wire       hm_resp_valid,
	input wire [7:0] hm_resp_status,
	input wire [7:0] hm_resp_error,
	input wire       hm_enabled
);
	// ------
	// decoded health command
	// ------
	wire hm  = cmd_write && cmd_byte == `HM_CMD;
	wire key = lba_mid == `HM_KEY_MID && lba_high == `HM_KEY_HIGH;
	wire sub = features >= 8'hD0 && features <= 8'hDA && features != 8'hD7;
	wire ok  = hm && key && sub && (hm_enabled || features == `HM_SUB_ENABLE);

	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	// aborted command answer
	property abort_p(c);
		c |=> hm_resp_valid && hm_resp_status == 8'h51 && hm_resp_error == 8'h04;
	endproperty

	a_key_abort: assert property (abort_p(hm && !key))
		else $error("missing key not aborted");
	a_sub_abort: assert property (abort_p(hm && key && !sub))
		else $error("bad subcommand not aborted");
	a_off_abort: assert property (abort_p(hm && key && sub && !ok))
		else $error("disabled command not aborted");
	a_read_fail: assert property (ok && attr_rd_fail &&
		features[7:1] == 7'h68 |=> hm_resp_status == 8'h51 &&
		hm_resp_error == 8'h10)
		else $error("table read failure not reported");
	a_write_fail: assert property (ok && attr_wr_fail &&
		features == 8'hD3 |=> hm_resp_status == 8'h51 &&
		hm_resp_error == 8'h40)
		else $error("table write failure not reported");
	a_resp_once: assert property (hm_resp_valid == $past(hm))
		else $error("answer without health command");
	a_off_clears: assert property (ok && features == `HM_SUB_DISABLE
		|=> !hm_enabled)
		else $error("disable left monitoring on");
	a_rd_answer: assert property (rd_valid == $past(rd_en))
		else $error("read answer out of step");
	a_busy_ends: assert property (sel_busy |-> ##[1:200] !sel_busy)
		else $error("progress write never ends");

	c_key: cover property (hm && !key);
	c_disable: cover property (ok && features == `HM_SUB_DISABLE);
	c_busy: cover property ($rose(sel_busy));
endmodule // hlr_monitor

bind health_log_recorder hlr_monitor mon (.*);

// file: dv/ata_host_model.sv
// Purpose: host side for the command block and sector ports
// Assumes: drives on the falling edge of core_clk
// Notes:   shadow registers keep their value between commands
`timescale 1ns/1ps

module ata_host_model (
	// clock and answers
	input  wire       core_clk,
	input  wire       rd_valid,
	input  wire [7:0] rd_data,
	// command block
	output reg        cmd_write   = 1'b0,
	output reg  [7:0] cmd_byte    = 8'h00,
	output reg  [7:0] dev_ctl     = 8'h00,
	output reg  [7:0] features    = 8'h00,
	output reg  [7:0] sect_cnt    = 8'h00,
	output reg  [7:0] lba_low     = 8'h00,
	output reg  [7:0] lba_mid     = 8'h00,
	output reg  [7:0] lba_high    = 8'h00,
	output reg  [7:0] dev_head    = 8'h00,
	output reg  [3:0] dev_state   = 4'h0,
	// sector access
	output reg        rd_en       = 1'b0,
	output reg  [1:0] rd_sel      = 2'h0,
	output reg  [8:0] rd_addr     = 9'h000,
	output reg        sel_wr_en   = 1'b0,
	output reg  [8:0] sel_wr_addr = 9'h000,
	output reg  [7:0] sel_wr_data = 8'h00
);
	// ------
	// host cycles
	// ------
	// one command write; the other fields follow from the four given
	task cmd(input [7:0] c, input [7:0] f, input [7:0] m, input [7:0] h);
		@(negedge core_clk);
		cmd_byte = c;
		features = f;
		lba_mid = m;
		lba_high = h;
		dev_ctl = f ^ 8'h08;
		sect_cnt = c + 8'h01;
		lba_low = f + m;
		dev_head = {4'hE, h[3:0]};
		dev_state = c[3:0];
		cmd_write = 1'b1;
		@(negedge core_clk);
		cmd_write = 1'b0;
	endtask

	// address is scrambled once taken, so stale values never match
	task rd(input [1:0] s, input [8:0] a, output [7:0] d);
		@(negedge core_clk);
		rd_sel = s;
		rd_addr = a;
		rd_en = 1'b1;
		@(negedge core_clk);
		rd_en = 1'b0;
		rd_addr = ~a;
		d = rd_valid ? rd_data : 8'hXX;
	endtask

	task wr(input [8:0] a, input [7:0] v);
		@(negedge core_clk);
		sel_wr_addr = a;
		sel_wr_data = v;
		sel_wr_en = 1'b1;
		@(negedge core_clk);
		sel_wr_en = 1'b0;
		sel_wr_data = ~v;
	endtask
endmodule // ata_host_model

// file: dv/health_log_recorder_test.sv
// Purpose: self-checking bench for the health log recorder
// Assumes: one millisecond is four cycles in this run
// Notes:   sectors are read whole and checked from a local copy
`timescale 1ns/1ps

module health_log_recorder_test;
	reg         core_clk = 1'b0;
	reg         reset = 1'b1;
	reg         cmd_fail = 1'b0, st_done = 1'b0, prog_update = 1'b0;
	reg         attr_rd_fail = 1'b0, attr_wr_fail = 1'b0;
	reg  [55:0] dn = 56'h0;
	reg  [55:0] st = 56'h0;
	reg  [79:0] pg = 80'h0;
	reg  [15:0] life = 16'h0;
	wire        cmd_write, rd_en, sel_wr_en, rd_valid, sel_busy;
	wire        hm_resp_valid, hm_enabled;
	wire [7:0]  cmd_byte, dev_ctl, features, sect_cnt, lba_low, lba_mid;
	wire [7:0]  lba_high, dev_head, sel_wr_data, rd_data;
	wire [7:0]  hm_resp_status, hm_resp_error;
	wire [8:0]  rd_addr, sel_wr_addr;
	wire [3:0]  dev_state;
	wire [1:0]  rd_sel;
	integer     failures = 0, n_tests = 0, i, j, k;
	reg  [7:0]  v;
	reg  [7:0]  b [0:511];
	reg  [63:0] snap [0:4];
	// feature, mid, high, flags {en,-,wr,rd}, status, error
	reg  [47:0] row [0:18] = '{48'hD04EC2105104, 48'hD04FC3105104,
		48'hCF4FC2105104, 48'hD74FC2105104, 48'hDB4FC2105104,
		48'hD04FC2105000, 48'hD14FC2105000, 48'hD24FC2105000,
		48'hD44FC2105000, 48'hD54FC2105000, 48'hD64FC2105000,
		48'hDA4FC2105000, 48'hD34FC2105000, 48'hD04FC2115110,
		48'hD14FC2115110, 48'hD34FC2125140, 48'hD94FC2005000,
		48'hD04FC2005104, 48'hD84FC2105000};

	always #2 core_clk = ~core_clk;

	health_log_recorder #(.CYCLES_PER_MS(4)) dut (.*,
		.done_error(dn[7:0]), .done_sect_cnt(dn[15:8]),
		.done_lba_low(dn[23:16]), .done_lba_mid(dn[31:24]),
		.done_lba_high(dn[39:32]), .done_dev_head(dn[47:40]),
		.done_status(dn[55:48]), .life_stamp(life),
		.st_number(st[7:0]), .st_status(st[15:8]),
		.st_checkpoint(st[23:16]), .st_fail_lba(st[55:24]),
		.prog_lba(pg[63:0]), .prog_span(pg[79:64]));

	ata_host_model host (.*);

	// ------
	// helpers
	// ------
	task chk(input [79:0] got, input [79:0] exp);
		n_tests = n_tests + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task results;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task wt(input integer n);
		repeat (n) @(negedge core_clk);
	endtask

	// whole sector into b, byte sum must come out zero
	task dump(input [1:0] s);
		v = 8'h00;
		for (k = 0; k < 512; k = k + 1) begin
			host.rd(s, k[8:0], b[k]);
			v = v + b[k];
		end
		chk(v, 8'h00);
	endtask

	// ------
	// main sequence
	// ------
	initial begin
		wt(8);
		chk({hm_resp_status, hm_enabled}, {8'h50, 1'b1});
		reset = 1'b0;
		wt(2);
		host.rd(2'h1, 9'h1FC, v);
		chk(v, 8'h00);
		// answer table, attribute levels move with the rows
		for (i = 0; i < 19; i = i + 1) begin
			{attr_wr_fail, attr_rd_fail} = row[i][17:16];
			host.cmd(8'hB0, row[i][47:40], row[i][39:32], row[i][31:24]);
			chk({hm_resp_valid, hm_enabled, hm_resp_status, hm_resp_error},
				{1'b1, row[i][20], row[i][15:0]});
		end
		// five commands eight cycles apart, state codes 0 to 4
		for (i = 0; i < 5; i = i + 1) begin
			host.cmd(8'h20 + i[7:0], 8'h10 * i[7:0], 8'h30 + i[7:0], 8'h41);
			snap[i] = {cmd_byte, dev_head, lba_high, lba_mid, lba_low, sect_cnt,
				features, dev_ctl};
			wt(6);
		end
		dn = 56'h51E0332211050A;
		life = 16'hA55A;
		cmd_fail = 1'b1;
		wt(1);
		cmd_fail = 1'b0;
		wt(100);
		dump(2'h0);
		chk(b[1], 8'h01);
		for (i = 0; i < 5; i = i + 1)
			for (j = 0; j < 8; j = j + 1)
				chk(b[2 + 12 * i + j], snap[i][8 * j +: 8]);
		chk({b[61], b[60], b[59], b[58]} - {b[13], b[12], b[11], b[10]},
			32'h8);
		chk(b[62], 8'h00);
		for (j = 0; j < 7; j = j + 1)
			chk(b[63 + j], dn[8 * j +: 8]);
		chk(b[89], {4'h0, dev_state});
		chk({b[91], b[90]}, life);
		chk({b[453], b[452]}, 16'h0001);
		// five more failures wrap the pointer, host writes meanwhile
		for (i = 0; i < 5; i = i + 1) begin
			cmd_fail = 1'b1;
			wt(1);
			cmd_fail = 1'b0;
			host.wr(9'h003, 8'h5A);
			wt(100);
		end
		dump(2'h0);
		chk({b[1], b[453], b[452]}, 24'h010006);
		// twenty-two self-tests, one more than the log holds
		for (i = 1; i <= 22; i = i + 1) begin
			st = {24'h123456, i[7:0], 8'h20 + i[7:0], 8'h5C, i[7:0]};
			life = 16'h0100 + i[15:0];
			st_done = 1'b1;
			wt(1);
			st_done = 1'b0;
			wt(30);
			if (i == 1) begin
				host.rd(2'h1, 9'h1FC, v);
				chk(v, 8'h01);
			end
		end
		dump(2'h1);
		chk({b[508], b[482]}, 16'h0115);
		chk({b[10], b[9], b[8], b[7], b[6], b[5], b[4], b[3], b[2]},
			{st[55:24], st[23:16], life, st[15:8], st[7:0]});
		// progress write, a host write refused while busy
		pg = 80'h00030102030405060708;
		prog_update = 1'b1;
		wt(1);
		prog_update = 1'b0;
		wt(2);
		chk(sel_busy, 1'b1);
		host.wr(9'h1F6, 8'h77);
		for (j = 0; j < 50 && sel_busy !== 1'b0; j = j + 1)
			wt(1);
		if (j == 50)
			failures = failures + 1;
		host.wr(9'h002, 8'hA1);
		host.wr(9'h051, 8'hB2);
		host.wr(9'h1F7, 8'hC3);
		host.wr(9'h1FD, 8'hD4);
		host.wr(9'h052, 8'hEE);
		host.wr(9'h1F4, 8'hEE);
		dump(2'h2);
		chk({b[2], b[3], b[81], b[503], b[509], b[82], b[502]},
			56'hA15AB2C3D40000);
		chk({b[501], b[500], b[499], b[498], b[497], b[496], b[495], b[494],
			b[493], b[492]}, pg);
		results;
	end
endmodule // health_log_recorder_test
